/* File: verilog/output_stage_cfg.svh */
// Register indices, field positions, reset values and timing for the output stage controls.
`ifndef OUTPUT_STAGE_CFG_SVH
`define OUTPUT_STAGE_CFG_SVH

`define IDX_PM_ONE          6'h01
`define IDX_PM_TWO          6'h02
`define IDX_PM_THREE        6'h03
`define IDX_ADDITIONAL      6'h07
`define IDX_AMP_MODE        6'h17
`define IDX_OUTPUT_CONTROL  6'h31
`define IDX_LEFT_VOLUME     6'h36
`define IDX_RIGHT_VOLUME    6'h37
`define IDX_LEFT_AUX_MIX    6'h38
`define IDX_RIGHT_AUX_MIX   6'h39
`define IDX_STATUS          6'h3A

`define RST_ZERO            9'h000
`define RST_ADDITIONAL      9'h080
`define RST_VOLUME          8'h39
`define RST_GAIN            6'h39
`define RST_AUX_MIX         9'h001

`define BIT_BIAS_ON         2
`define BIT_LEFT_AUX_MIX    6
`define BIT_RIGHT_AUX_MIX   7
`define BIT_LEFT_PRIMARY    7
`define BIT_RIGHT_PRIMARY   8
`define BIT_SLEEP           6
`define BIT_LEFT_OUT_MIX    2
`define BIT_RIGHT_OUT_MIX   3
`define BIT_LEFT_SECONDARY  5
`define BIT_RIGHT_SECONDARY 6
`define BIT_LEFT_AUX_LINE   7
`define BIT_RIGHT_AUX_LINE  8
`define BIT_TICK_ENABLE     0
`define MSB_DIVIDER         7
`define LSB_DIVIDER         4
`define BIT_AMP_SELECT      8
`define BIT_IDLE_RESIST     0
`define BIT_SENSOR_ON       1
`define BIT_CUTOFF_ON       2
`define MSB_GAIN            5
`define BIT_SILENCE         6
`define BIT_CROSS_GATE      7
`define BIT_COMMIT          8
`define BIT_AUX_SILENCE     6
`define BIT_AUX_CUT         5
`define BIT_AUX_CROSS_FEED  7
`define MSB_LEFT_SOURCES    3

`define DIV_CODE_1          4'h0
`define DIV_CODE_2          4'h2
`define DIV_CODE_3          4'h3
`define DIV_CODE_4          4'h4
`define DIV_CODE_5P5        4'h5
`define DIV_CODE_6          4'h6
`define DIV_CODE_8          4'h8
`define DIV_CODE_12A        4'h9
`define DIV_CODE_12B        4'hA
`define DIV_LAST_1          4'h0
`define DIV_LAST_2          4'h1
`define DIV_LAST_3          4'h2
`define DIV_LAST_4          4'h3
`define DIV_LAST_5          4'h4
`define DIV_LAST_6          4'h5
`define DIV_LAST_8          4'h7
`define DIV_LAST_12         4'hB

`define TIMEOUT_CYCLES_DEFAULT 2097152
`define TIMEOUT_WIDTH       22

`endif

/* File: verilog/output_stage_pkg.sv */
// Types shared by the output stage control logic.
package output_stage_pkg;

    typedef struct packed {
        logic [5:0] gain;
        logic       silence;
    } secondary_chan_t;

    typedef struct packed {
        logic [3:0] leftSources;
        logic       leftSilence;
        logic [5:0] rightSources;
        logic       rightSilence;
        logic       rightSixDbCut;
    } aux_line_t;

    typedef struct packed {
        logic biasBuffer;
        logic leftAuxMixer;
        logic rightAuxMixer;
        logic leftPrimaryHp;
        logic rightPrimaryHp;
        logic leftOutputMixer;
        logic rightOutputMixer;
        logic leftSecondary;
        logic rightSecondary;
        logic leftAuxLine;
        logic rightAuxLine;
    } stage_enable_t;

    typedef enum logic [1:0] {
        GAIN_IDLE = 2'b01,
        GAIN_WAIT = 2'b10
    } gain_state_t;

endpackage

/* File: verilog/output_stage_control_regs.sv */
// Control registers and digital side effects of the secondary and auxiliary output stages.
//
// Contract
// - Divide system clock by coded switching divider.
// - Mode bit selects class AB or D.
// - Six-bit gain per channel, reset 0 dB.
// - Silence bit mutes, keeps quiescent level.
// - Crossing gate delays gain to zero crossing.
// - Gains pend until commit bit written.
// - Force pending gain after timeout without crossing.
// - Timeout tick enable bit zero, reset 0.
// - Same enable clocks jack detect debounce.
// - Left aux mixer four source selects.
// - Right aux mixer six source selects.
// - Aux line silence bit six.
// - Right aux six dB cut bit.
// - Every stage enable resets off.
// - First power register holds bias, aux mixers.
// - Sleep bit stops internal clock use.
// - Overheat with both enables kills outputs.
// - Overheat with sensor clears virtual bit.
// - Cutoff enable bit two, reset 0.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "output_stage_cfg.svh"

module output_stage_control_regs
    import output_stage_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  zeroCross,
    input  wire logic        overTemp,
    output secondary_chan_t  leftSecondaryOut,
    output secondary_chan_t  rightSecondaryOut,
    output logic             switchingAmpSelect,
    output logic             switchClockTick,
    output logic             debounceClockOn,
    output logic             idleResistHigh,
    output aux_line_t        auxLineOut,
    output stage_enable_t    stageEnable,
    output logic             thermalGood,
    output logic             thermalCutoffActive
);

    logic [8:0]  pmOne_reg;
    logic [8:0]  pmTwo_reg;
    logic [8:0]  pmThree_reg;
    logic [8:0]  additional_reg;
    logic [8:0]  ampMode_reg;
    logic [8:0]  outputControl_reg;
    logic [7:0]  volume_reg [0:1];
    logic [8:0]  leftAuxMix_reg;
    logic [8:0]  rightAuxMix_reg;
    logic [5:0]  appliedGain_reg [0:1];
    gain_state_t gainState_reg [0:1];
    logic        commit_reg;
    logic [3:0]  divCount_reg;
    logic        divPhase_reg;
    logic [`TIMEOUT_WIDTH-1:0] timeout_reg;

    logic        setupPhase;
    logic        writeStrobe;
    logic [5:0]  index;
    logic        mapped;
    logic [8:0]  readValue;
    logic        clockRun;
    logic        tickEnable;
    logic        anyWaiting;
    logic        timeoutHit;
    logic        shutdown;
    logic [3:0]  divLast;

    function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
        hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    function automatic logic [3:0] lastCount(input logic [3:0] code, input logic phase);
        unique case (code)
            `DIV_CODE_1:   lastCount = `DIV_LAST_1;
            `DIV_CODE_2:   lastCount = `DIV_LAST_2;
            `DIV_CODE_3:   lastCount = `DIV_LAST_3;
            `DIV_CODE_4:   lastCount = `DIV_LAST_4;
            `DIV_CODE_5P5: lastCount = phase ? `DIV_LAST_6 : `DIV_LAST_5;
            `DIV_CODE_6:   lastCount = `DIV_LAST_6;
            `DIV_CODE_12A: lastCount = `DIV_LAST_12;
            `DIV_CODE_12B: lastCount = `DIV_LAST_12;
            default:       lastCount = `DIV_LAST_8;
        endcase
    endfunction

    // APB decode: one wait-free access phase, answered from flip-flops.
    assign setupPhase  = psel && !penable;
    assign writeStrobe = psel && penable && pwrite && pready;
    assign index       = paddr[7:2];

    always_comb begin
        mapped    = 1'b1;
        readValue = `RST_ZERO;
        if (paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else begin
            unique case (index)
                `IDX_PM_ONE:         readValue = pmOne_reg;
                `IDX_PM_TWO:         readValue = pmTwo_reg;
                `IDX_PM_THREE:       readValue = pmThree_reg;
                `IDX_ADDITIONAL:     readValue = additional_reg;
                `IDX_AMP_MODE:       readValue = ampMode_reg;
                `IDX_OUTPUT_CONTROL: readValue = outputControl_reg;
                `IDX_LEFT_VOLUME:    readValue = {1'b0, volume_reg[0]};
                `IDX_RIGHT_VOLUME:   readValue = {1'b0, volume_reg[1]};
                `IDX_LEFT_AUX_MIX:   readValue = leftAuxMix_reg;
                `IDX_RIGHT_AUX_MIX:  readValue = rightAuxMix_reg;
                `IDX_STATUS:         readValue = {5'h00, shutdown, overTemp,
                                                  gainState_reg[1] == GAIN_WAIT,
                                                  gainState_reg[0] == GAIN_WAIT};
                default:             mapped = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setupPhase;
            pslverr <= setupPhase && !mapped;
            if (setupPhase) begin
                prdata <= {23'h00_0000, readValue};
            end
        end
    end

    // Plain control registers; a write replaces all nine bits.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pmOne_reg         <= `RST_ZERO;
            pmTwo_reg         <= `RST_ZERO;
            pmThree_reg       <= `RST_ZERO;
            additional_reg    <= `RST_ADDITIONAL;
            ampMode_reg       <= `RST_ZERO;
            outputControl_reg <= `RST_ZERO;
            leftAuxMix_reg    <= `RST_AUX_MIX;
            rightAuxMix_reg   <= `RST_AUX_MIX;
        end else if (writeStrobe) begin
            if (hit(paddr, `IDX_PM_ONE)) begin
                pmOne_reg <= pwdata[8:0];
            end
            if (hit(paddr, `IDX_PM_TWO)) begin
                pmTwo_reg <= pwdata[8:0];
            end
            if (hit(paddr, `IDX_PM_THREE)) begin
                pmThree_reg <= pwdata[8:0];
            end
            if (hit(paddr, `IDX_ADDITIONAL)) begin
                additional_reg <= pwdata[8:0];
            end
            if (hit(paddr, `IDX_AMP_MODE)) begin
                ampMode_reg <= pwdata[8:0];
            end
            if (hit(paddr, `IDX_OUTPUT_CONTROL)) begin
                outputControl_reg <= pwdata[8:0];
            end
            if (hit(paddr, `IDX_LEFT_AUX_MIX)) begin
                leftAuxMix_reg <= pwdata[8:0];
            end
            if (hit(paddr, `IDX_RIGHT_AUX_MIX)) begin
                rightAuxMix_reg <= pwdata[8:0];
            end
        end
    end

    // Volume registers hold pending gain; the commit bit is never stored.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            volume_reg[0] <= `RST_VOLUME;
            volume_reg[1] <= `RST_VOLUME;
            commit_reg    <= 1'b0;
        end else begin
            if (writeStrobe && hit(paddr, `IDX_LEFT_VOLUME)) begin
                volume_reg[0] <= pwdata[7:0];
            end
            if (writeStrobe && hit(paddr, `IDX_RIGHT_VOLUME)) begin
                volume_reg[1] <= pwdata[7:0];
            end
            commit_reg <= writeStrobe && pwdata[`BIT_COMMIT] &&
                          (hit(paddr, `IDX_LEFT_VOLUME) ||
                           hit(paddr, `IDX_RIGHT_VOLUME));
        end
    end

    assign clockRun   = !pmTwo_reg[`BIT_SLEEP];
    assign tickEnable = additional_reg[`BIT_TICK_ENABLE];
    assign anyWaiting = (gainState_reg[0] == GAIN_WAIT) || (gainState_reg[1] == GAIN_WAIT);
    assign timeoutHit = timeout_reg == `TIMEOUT_WIDTH'(TIMEOUT_CYCLES - 1);
    assign shutdown   = overTemp && outputControl_reg[`BIT_SENSOR_ON] &&
                        outputControl_reg[`BIT_CUTOFF_ON];

    // Counts system clocks since the last crossing while a gain waits.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            timeout_reg <= '0;
        end else if (!clockRun || !tickEnable || !anyWaiting || (|zeroCross) || timeoutHit) begin
            timeout_reg <= '0;
        end else begin
            timeout_reg <= timeout_reg + 1'b1;
        end
    end

    // Per-channel gain apply: at once, on a crossing, or on timeout.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < 2; i++) begin
                appliedGain_reg[i] <= `RST_GAIN;
                gainState_reg[i]   <= GAIN_IDLE;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                unique case (gainState_reg[i])
                    GAIN_IDLE: begin
                        if (commit_reg) begin
                            if (volume_reg[i][`BIT_CROSS_GATE]) begin
                                gainState_reg[i] <= GAIN_WAIT;
                            end else begin
                                appliedGain_reg[i] <= volume_reg[i][`MSB_GAIN:0];
                            end
                        end
                    end
                    GAIN_WAIT: begin
                        if (zeroCross[i] || timeoutHit ||
                            !volume_reg[i][`BIT_CROSS_GATE]) begin
                            appliedGain_reg[i] <= volume_reg[i][`MSB_GAIN:0];
                            gainState_reg[i]   <= GAIN_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Switching clock divider; code 5.5 alternates five and six cycles.
    assign divLast = lastCount(additional_reg[`MSB_DIVIDER:`LSB_DIVIDER], divPhase_reg);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            divCount_reg    <= 4'h0;
            divPhase_reg    <= 1'b0;
            switchClockTick <= 1'b0;
        end else if (!clockRun) begin
            switchClockTick <= 1'b0;
        end else if (divCount_reg >= divLast) begin
            divCount_reg    <= 4'h0;
            divPhase_reg    <= !divPhase_reg;
            switchClockTick <= 1'b1;
        end else begin
            divCount_reg    <= divCount_reg + 4'h1;
            switchClockTick <= 1'b0;
        end
    end

    // Registered copies of the control fields that drive the analogue stages.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            leftSecondaryOut   <= '{gain: `RST_GAIN, silence: 1'b0};
            rightSecondaryOut  <= '{gain: `RST_GAIN, silence: 1'b0};
            switchingAmpSelect <= 1'b0;
            debounceClockOn    <= 1'b0;
            idleResistHigh     <= 1'b0;
            auxLineOut         <= '0;
        end else begin
            leftSecondaryOut.gain     <= appliedGain_reg[0];
            rightSecondaryOut.gain    <= appliedGain_reg[1];
            leftSecondaryOut.silence  <= volume_reg[0][`BIT_SILENCE];
            rightSecondaryOut.silence <= volume_reg[1][`BIT_SILENCE];
            switchingAmpSelect        <= ampMode_reg[`BIT_AMP_SELECT];
            debounceClockOn           <= tickEnable && clockRun;
            idleResistHigh            <= outputControl_reg[`BIT_IDLE_RESIST];
            auxLineOut.leftSources    <= leftAuxMix_reg[`MSB_LEFT_SOURCES:0];
            auxLineOut.leftSilence    <= leftAuxMix_reg[`BIT_AUX_SILENCE];
            auxLineOut.rightSources   <= {rightAuxMix_reg[`BIT_AUX_CROSS_FEED],
                                          rightAuxMix_reg[4:0]};
            auxLineOut.rightSilence   <= rightAuxMix_reg[`BIT_AUX_SILENCE];
            auxLineOut.rightSixDbCut  <= rightAuxMix_reg[`BIT_AUX_CUT];
        end
    end

    // Stage enables, all forced off while the thermal cutoff is active.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stageEnable         <= '0;
            thermalGood         <= 1'b1;
            thermalCutoffActive <= 1'b0;
        end else begin
            stageEnable.biasBuffer       <= pmOne_reg[`BIT_BIAS_ON] && !shutdown;
            stageEnable.leftAuxMixer     <= pmOne_reg[`BIT_LEFT_AUX_MIX] && !shutdown;
            stageEnable.rightAuxMixer    <= pmOne_reg[`BIT_RIGHT_AUX_MIX] && !shutdown;
            stageEnable.leftPrimaryHp    <= pmTwo_reg[`BIT_LEFT_PRIMARY] && !shutdown;
            stageEnable.rightPrimaryHp   <= pmTwo_reg[`BIT_RIGHT_PRIMARY] && !shutdown;
            stageEnable.leftOutputMixer  <= pmThree_reg[`BIT_LEFT_OUT_MIX] && !shutdown;
            stageEnable.rightOutputMixer <= pmThree_reg[`BIT_RIGHT_OUT_MIX] && !shutdown;
            stageEnable.leftSecondary    <= pmThree_reg[`BIT_LEFT_SECONDARY] && !shutdown;
            stageEnable.rightSecondary   <= pmThree_reg[`BIT_RIGHT_SECONDARY] && !shutdown;
            stageEnable.leftAuxLine      <= pmThree_reg[`BIT_LEFT_AUX_LINE] && !shutdown;
            stageEnable.rightAuxLine     <= pmThree_reg[`BIT_RIGHT_AUX_LINE] && !shutdown;
            thermalGood         <= !(overTemp && outputControl_reg[`BIT_SENSOR_ON]);
            thermalCutoffActive <= shutdown;
        end
    end

endmodule // output_stage_control_regs

/* File: testbench/output_stage_control_regs_asserts.sv */
// Concurrent checks on the ports of the output stage control registers.
`timescale 1ns/1ps
module output_stage_control_regs_asserts
    import output_stage_pkg::*;
(
    input wire logic            clk,
    input wire logic            rst_b,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic            overTemp,
    input wire secondary_chan_t leftSecondaryOut,
    input wire aux_line_t       auxLineOut,
    input wire stage_enable_t   stageEnable,
    input wire logic            thermalGood,
    input wire logic            thermalCutoffActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_error_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    a_misaligned_refused: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    a_silence_follows: assert property (psel && penable && pready && pwrite && paddr == 8'hD8
        |-> ##2 leftSecondaryOut.silence == $past(pwdata[6], 2))
        else $error("left silence not taken from write");
    a_aux_cut_follows: assert property (psel && penable && pready && pwrite && paddr == 8'hE4
        |-> ##2 auxLineOut.rightSixDbCut == $past(pwdata[5], 2)
        && auxLineOut.rightSilence == $past(pwdata[6], 2))
        else $error("right aux cut or silence not taken from write");
    a_stage_from_pm3: assert property (psel && penable && pready && pwrite && paddr == 8'h0C
        |-> ##2 thermalCutoffActive || stageEnable.leftSecondary == $past(pwdata[5], 2))
        else $error("secondary enable not taken from write");
    a_cutoff_clears_all: assert property ($past(thermalCutoffActive) && thermalCutoffActive
        |-> stageEnable == '0)
        else $error("stage enabled during cutoff");
    a_cutoff_needs_heat: assert property (thermalCutoffActive |-> $past(overTemp))
        else $error("cutoff without over temperature");
    a_good_needs_heat: assert property (!thermalGood |-> $past(overTemp))
        else $error("thermal bit low without over temperature");

    c_refused: cover property (pslverr);
    c_cutoff: cover property (thermalCutoffActive);
    c_gain_change: cover property ($changed(leftSecondaryOut.gain));
endmodule // output_stage_control_regs_asserts

bind output_stage_control_regs output_stage_control_regs_asserts u_asserts (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overTemp(overTemp), .leftSecondaryOut(leftSecondaryOut), .auxLineOut(auxLineOut),
    .stageEnable(stageEnable), .thermalGood(thermalGood),
    .thermalCutoffActive(thermalCutoffActive)
);

/* File: testbench/tb_top.sv */
// Self-checking bench for the output stage control registers.
`timescale 1ns/1ps
module tb_top
    import output_stage_pkg::*;
();
    localparam int TO = 64;
    logic            clk, rst_b, psel, penable, pwrite, overTemp;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata;
    logic            pready, pslverr, ampSel, tick, debounceOn, idleHigh, good, cutoff;
    logic [1:0]      zeroCross;
    secondary_chan_t leftOut, rightOut;
    aux_line_t       auxOut;
    stage_enable_t   stageOut;
    logic [33:0]     expQ [$];
    logic [33:0]     e;
    logic [31:0]     v [10];
    logic [5:0]      gl;
    int              nErrors, nTests, n;
    int              seed = 35063;
    logic [7:0]      addrs [10] = '{8'h04, 8'h08, 8'h0C, 8'h1C, 8'h5C, 8'hC4, 8'hD8, 8'hDC,
                                    8'hE0, 8'hE4};
    logic [31:0]     rsts [10] = '{32'h0, 32'h0, 32'h0, 32'h80, 32'h0, 32'h0, 32'h39, 32'h39,
                                   32'h1, 32'h1};
    logic [3:0]      codes [10] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'h7};
    int              spans [10] = '{2, 4, 6, 8, 11, 12, 16, 24, 24, 16};

    output_stage_control_regs #(.TIMEOUT_CYCLES(TO)) u_dut (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .zeroCross(zeroCross), .overTemp(overTemp), .leftSecondaryOut(leftOut),
        .rightSecondaryOut(rightOut), .switchingAmpSelect(ampSel), .switchClockTick(tick),
        .debounceClockOn(debounceOn), .idleResistHigh(idleHigh), .auxLineOut(auxOut),
        .stageEnable(stageOut), .thermalGood(good), .thermalCutoffActive(cutoff));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        nTests++;
        if (seen !== want) begin
            nErrors++;
            $display("mismatch at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] rd, input logic err);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        expQ.push_back({~w, err, rd});
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            nErrors++;
            $display("mismatch at %0t: no pready", $time);
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic span(output int len);
        int seen;
        seen = 0;
        len = 0;
        for (int i = 0; i < 100 && seen < 4; i++) begin
            @(posedge clk);
            if (seen > 1) len++;
            if (tick === 1'b1) seen++;
        end
    endtask

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && expQ.size() > 0) begin
            e = expQ.pop_front();
            check({31'h0, pslverr}, {31'h0, e[32]}, "error flag");
            if (e[33]) check(prdata, e[31:0], "read data");
        end
    end

    initial begin
        {rst_b, psel, penable, pwrite, overTemp, zeroCross, paddr, pwdata} = '0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 10; k++) apb(1'b0, addrs[k], rsts[k], rsts[k], 1'b0);
        check(leftOut.gain, 6'h39, "left gain");
        check(stageOut, 11'h0, "enables");
        check({auxOut.leftSources, auxOut.rightSources}, 10'h041, "aux sources");
        check(good, 1'b1, "thermal bit");
        span(n);
        check(n, 16, "reset divider");
        $display("test reset done");
        apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h05, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h44, 32'h1FF, 32'h0, 1'b1);
        wr(8'hE8, 32'h1FF);
        apb(1'b0, 8'hE8, 32'h0, 32'h0, 1'b0);
        $display("test refusal done");
        for (int k = 0; k < 10; k++) begin
            if (k == 6 || k == 7) continue;
            v[k] = $random(seed) & 32'h1FF;
            wr(addrs[k], v[k]);
            apb(1'b0, addrs[k], 32'h0, v[k], 1'b0);
        end
        repeat (3) @(posedge clk);
        check(stageOut, {v[0][2], v[0][6], v[0][7], v[1][7], v[1][8], v[2][2], v[2][3], v[2][5],
              v[2][6], v[2][7], v[2][8]}, "enables");
        check(auxOut, {v[8][3:0], v[8][6], v[9][7], v[9][4:0], v[9][6], v[9][5]}, "aux");
        check(ampSel, v[4][8], "amp mode");
        check(idleHigh, v[5][0], "idle resistance");
        check(debounceOn, v[3][0] & ~v[1][6], "debounce clock");
        for (int k = 0; k < 10; k++) wr(addrs[k], rsts[k]);
        $display("test fields done");
        gl = 6'($random(seed)) & 6'h1F;
        wr(8'hD8, {25'h0, 1'b1, gl});
        repeat (4) @(posedge clk);
        check(leftOut.gain, 6'h39, "held gain");
        check(leftOut.silence, 1'b1, "silence");
        wr(8'hDC, 32'h13F);
        repeat (5) @(posedge clk);
        check({leftOut.gain, rightOut.gain}, {gl, 6'h3F}, "committed gains");
        wr(8'hD8, 32'h180);
        repeat (TO + 20) @(posedge clk);
        check(leftOut, {gl, 1'b0}, "gated gain");
        zeroCross <= 2'h1;
        @(posedge clk);
        zeroCross <= 2'h0;
        repeat (4) @(posedge clk);
        check(leftOut.gain, 6'h00, "crossing gain");
        wr(8'h1C, 32'h81);
        wr(8'hD8, 32'h1A2);
        repeat (TO / 2) @(posedge clk);
        check(leftOut.gain, 6'h00, "before timeout");
        repeat (TO / 2 + 10) @(posedge clk);
        check(leftOut.gain, 6'h22, "after timeout");
        check(debounceOn, 1'b1, "debounce clock");
        $display("test gain done");
        for (int k = 0; k < 10; k++) begin
            wr(8'h1C, {24'h0, codes[k], 4'h0});
            span(n);
            check(n, spans[k], "divider span");
        end
        wr(8'h08, 32'h40);
        span(n);
        check(n, 0, "sleep ticks");
        check(debounceOn, 1'b0, "sleep debounce");
        wr(8'h08, 32'h0);
        $display("test divider done");
        wr(8'h0C, 32'h1EC);
        wr(8'hC4, 32'h2);
        @(posedge clk);
        overTemp <= 1'b1;
        repeat (3) @(posedge clk);
        check({good, stageOut.rightAuxLine}, 2'h1, "sensor only");
        wr(8'hC4, 32'h6);
        repeat (3) @(posedge clk);
        check({stageOut, cutoff}, 12'h001, "cutoff");
        apb(1'b0, 8'hE8, 32'h0, 32'hC, 1'b0);
        overTemp <= 1'b0;
        repeat (3) @(posedge clk);
        check({good, stageOut.leftSecondary}, 2'h3, "recovered");
        $display("test thermal done");
        end_of_test();
    end

    initial begin
        repeat (100000) @(posedge clk);
        nErrors++;
        $display("mismatch at %0t: run too long", $time);
        end_of_test();
    end
endmodule // tb_top
